// *** core/pwm_timer_pkg.sv ***
// pwm_timer_pkg: shared constants for the eight-channel waveform timers.
// assumes one sys_clk domain; prescaled clock choices arrive as enable ticks.
package pwm_timer_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_PAIRS    = 4;
  localparam int BYTE_W       = 8;
  localparam int WIDE_W       = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] ZERO_BYTE   = 8'h00;
  localparam logic [WIDE_W-1:0] ZERO_WIDE   = 16'h0000;
  localparam logic [WIDE_W-1:0] ONE_WIDE    = 16'h0001;

  // clock choice per channel: 0 = plain prescaled clock, 1 = scaled clock
  localparam logic CLK_SEL_PLAIN = 1'b0;

endpackage

// *** core/pwm_timer_core.sv ***
// pwm_timer_core: one waveform timer, counter/period/duty of WIDTH bits.
// assumes tick is a one-cycle enable from the chosen prescaled clock.
`timescale 1ns/100ps

module pwm_timer_core
  import pwm_timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             tick,
  input  wire logic             enable,
  input  wire logic             center,
  input  wire logic             polarity,
  input  wire logic             cnt_write,
  input  wire logic [WIDTH-1:0] period_buf,
  input  wire logic [WIDTH-1:0] duty_buf,
  output logic      [WIDTH-1:0] count,
  output logic                  wave
);

  if (WIDTH < 2 || WIDTH > WIDE_W) begin : g_width_check
    $error("pwm_timer_core: WIDTH out of range");
  end

  localparam logic [WIDTH-1:0] ZERO = '0;
  localparam logic [WIDTH-1:0] ONE  = WIDTH'(1);

  logic [WIDTH-1:0] count_q, count_d;
  logic [WIDTH-1:0] per_q, per_d;
  logic [WIDTH-1:0] dty_q, dty_d;
  logic             down_q, down_d;
  logic             ff_q, ff_d;
  logic             wave_q, wave_d;
  logic             raw;

  // ----------------------------------------------------------------
  // counter, direction, active latches, output flip-flop
  // ----------------------------------------------------------------
  always_comb begin
    count_d = count_q;
    down_d  = down_q;
    ff_d    = ff_q;
    per_d   = per_q;
    dty_d   = dty_q;
    if (cnt_write) begin
      count_d = ZERO;
      down_d  = 1'b0;
      ff_d    = 1'b0;
      per_d   = period_buf;
      dty_d   = duty_buf;
    end else if (!enable) begin
      // disabled: buffers pass straight into the active latches
      per_d = period_buf;
      dty_d = duty_buf;
      if (period_buf == ZERO) begin
        count_d = ZERO;
      end
    end else if (tick) begin
      if (per_q == ZERO) begin
        count_d = ZERO;
        per_d   = period_buf;
        dty_d   = duty_buf;
      end else if (!center) begin
        // left aligned: 0 .. period-1, up only
        if (count_q + ONE == per_q) begin
          count_d = ZERO;
          ff_d    = 1'b0;
          per_d   = period_buf;
          dty_d   = duty_buf;
        end else begin
          count_d = count_q + ONE;
          if (count_q + ONE == dty_q) begin
            ff_d = ~ff_q;
          end
        end
      end else begin
        // center aligned: 0 .. period .. 0
        if (!down_q || count_q == ZERO) begin
          if (count_q == per_q) begin
            down_d  = 1'b1;
            count_d = count_q - ONE;
          end else begin
            down_d  = 1'b0;
            count_d = count_q + ONE;
          end
        end else begin
          count_d = count_q - ONE;
        end
        if (count_d == dty_q && count_d != ZERO) begin
          ff_d = ~ff_q;
        end
        if (down_d && count_d == ZERO) begin
          down_d = 1'b0;
          ff_d   = 1'b0;
          per_d  = period_buf;
          dty_d  = duty_buf;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // boundary cases and polarity
  // ----------------------------------------------------------------
  always_comb begin
    if (per_q == ZERO) begin
      raw = 1'b1;
    end else if (dty_q == ZERO) begin
      raw = 1'b0;
    end else if (dty_q >= per_q) begin
      raw = 1'b1;
    end else begin
      raw = ~ff_q;
    end
    wave_d = polarity ? raw : ~raw;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= ZERO;
      down_q  <= 1'b0;
      ff_q    <= 1'b0;
      per_q   <= ZERO;
      dty_q   <= ZERO;
      wave_q  <= 1'b0;
    end else if (clk_en) begin
      count_q <= count_d;
      down_q  <= down_d;
      ff_q    <= ff_d;
      per_q   <= per_d;
      dty_q   <= dty_d;
      wave_q  <= wave_d;
    end
  end

  assign count = count_q;
  assign wave  = wave_q;

endmodule

// *** core/pwm_channel_waveform_timers.sv ***
// pwm_channel_waveform_timers: eight 8-bit waveform timers, pairable to 16 bits.
// assumes prescaled clocks arrive as one-cycle ticks in the sys_clk domain,
// and that software writes counters by pulsing the per-channel write strobes.
`timescale 1ns/100ps

module pwm_channel_waveform_timers
  import pwm_timer_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic                         clk_en,
  input  wire logic                         tick_a,
  input  wire logic                         tick_b,
  input  wire logic                         tick_sa,
  input  wire logic                         tick_sb,
  input  wire logic [CHANNELS-1:0]          channel_enable_bit,
  input  wire logic [CHANNELS-1:0]          center_align_select,
  input  wire logic [CHANNELS-1:0]          channel_polarity_bit,
  input  wire logic [CHANNELS-1:0]          channel_clock_select,
  input  wire logic                         join_pair_0_1,
  input  wire logic                         join_pair_2_3,
  input  wire logic                         join_pair_4_5,
  input  wire logic                         join_pair_6_7,
  input  wire logic [CHANNELS*BYTE_W-1:0]   channel_period_value,
  input  wire logic [CHANNELS*BYTE_W-1:0]   channel_duty_value,
  input  wire logic [CHANNELS-1:0]          counter_write,
  output logic      [CHANNELS*BYTE_W-1:0]   channel_counter_value,
  output logic      [CHANNELS-1:0]          channel_out,
  output logic      [CHANNELS-1:0]          channel_out_en
);

  if (CHANNELS != NUM_CHANNELS) begin : g_channels_check
    $error("pwm_channel_waveform_timers: CHANNELS must be 8");
  end

  logic [NUM_PAIRS-1:0]        join_bits;
  logic [CHANNELS-1:0]         tick_ch;
  logic [CHANNELS-1:0]         wave8;
  logic [CHANNELS*BYTE_W-1:0]  count8;
  logic [NUM_PAIRS-1:0]        wave16;
  logic [NUM_PAIRS*WIDE_W-1:0] count16;

  assign join_bits = {join_pair_6_7, join_pair_4_5, join_pair_2_3, join_pair_0_1};

  // ----------------------------------------------------------------
  // clock choice: channels 0,1,4,5 use A/SA, 2,3,6,7 use B/SB
  // ----------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (c[1] == 1'b0) begin
        tick_ch[c] = (channel_clock_select[c] == CLK_SEL_PLAIN) ? tick_a : tick_sa;
      end else begin
        tick_ch[c] = (channel_clock_select[c] == CLK_SEL_PLAIN) ? tick_b : tick_sb;
      end
    end
  end

  // ----------------------------------------------------------------
  // per pair: two 8-bit timers plus one 16-bit timer
  // ----------------------------------------------------------------
  // both widths are built side by side; the join bit picks which one is live.
  // unused timers are held disabled: the count stops unless written or the period is zero, and the active latches follow the buffers.
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    localparam int EV = 2 * p;
    localparam int OD = 2 * p + 1;

    for (genvar k = 0; k < 2; k++) begin : g_byte
      localparam int CH = 2 * p + k;
      pwm_timer_core #(.WIDTH(BYTE_W)) u_t8 (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .tick       (tick_ch[CH]),
        .enable     (channel_enable_bit[CH] & ~join_bits[p]),
        .center     (center_align_select[CH]),
        .polarity   (channel_polarity_bit[CH]),
        .cnt_write  (counter_write[CH]),
        .period_buf (channel_period_value[CH*BYTE_W +: BYTE_W]),
        .duty_buf   (channel_duty_value[CH*BYTE_W +: BYTE_W]),
        .count      (count8[CH*BYTE_W +: BYTE_W]),
        .wave       (wave8[CH])
      );
    end

    pwm_timer_core #(.WIDTH(WIDE_W)) u_t16 (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .tick       (tick_ch[OD]),
      .enable     (channel_enable_bit[OD] & join_bits[p]),
      .center     (center_align_select[OD]),
      .polarity   (channel_polarity_bit[OD]),
      .cnt_write  (counter_write[EV] | counter_write[OD]),
      .period_buf ({channel_period_value[EV*BYTE_W +: BYTE_W],
                    channel_period_value[OD*BYTE_W +: BYTE_W]}),
      .duty_buf   ({channel_duty_value[EV*BYTE_W +: BYTE_W],
                    channel_duty_value[OD*BYTE_W +: BYTE_W]}),
      .count      (count16[p*WIDE_W +: WIDE_W]),
      .wave       (wave16[p])
    );
  end

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (join_bits[p]) begin
        channel_counter_value[2*p*BYTE_W +: BYTE_W]     = count16[p*WIDE_W + BYTE_W +: BYTE_W];
        channel_counter_value[(2*p+1)*BYTE_W +: BYTE_W] = count16[p*WIDE_W +: BYTE_W];
        channel_out[2*p]      = 1'b0;
        channel_out_en[2*p]   = 1'b0;
        channel_out[2*p+1]    = wave16[p];
        channel_out_en[2*p+1] = channel_enable_bit[2*p+1];
      end else begin
        channel_counter_value[2*p*BYTE_W +: BYTE_W]     = count8[2*p*BYTE_W +: BYTE_W];
        channel_counter_value[(2*p+1)*BYTE_W +: BYTE_W] = count8[(2*p+1)*BYTE_W +: BYTE_W];
        channel_out[2*p]      = wave8[2*p];
        channel_out_en[2*p]   = channel_enable_bit[2*p];
        channel_out[2*p+1]    = wave8[2*p+1];
        channel_out_en[2*p+1] = channel_enable_bit[2*p+1];
      end
    end
  end

endmodule

// *** sim/pwm_timers_properties.sv ***
// pwm_timers_properties: port-level checks for the eight waveform timers.
// assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/100ps
module pwm_timers_checker
  import pwm_timer_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic                       sys_clk,
  input wire logic                       rst_b,
  input wire logic                       clk_en,
  input wire logic [CHANNELS-1:0]        channel_enable_bit,
  input wire logic [CHANNELS-1:0]        center_align_select,
  input wire logic                       join_pair_0_1,
  input wire logic                       join_pair_2_3,
  input wire logic                       join_pair_4_5,
  input wire logic                       join_pair_6_7,
  input wire logic [CHANNELS*BYTE_W-1:0] channel_period_value,
  input wire logic [CHANNELS-1:0]        counter_write,
  input wire logic [CHANNELS*BYTE_W-1:0] channel_counter_value,
  input wire logic [CHANNELS-1:0]        channel_out,
  input wire logic [CHANNELS-1:0]        channel_out_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic [7:0] c4 = channel_counter_value[39:32];
  wire logic [7:0] c5 = channel_counter_value[47:40];

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_even_off; join_pair_0_1 |-> !channel_out_en[0] && !channel_out[0]; endproperty
  a_even_off: assert property (p_even_off) else $error("even output live while joined");
  property p_odd_en; channel_out_en[1] == channel_enable_bit[1]; endproperty
  a_odd_en: assert property (p_odd_en) else $error("odd output enable wrong");
  property p_write_clear; clk_en && counter_write[1] |=> channel_counter_value[15:8] == ZERO_BYTE; endproperty
  a_write_clear: assert property (p_write_clear) else $error("counter not cleared by write");
  property p_join_clear; clk_en && join_pair_0_1 && counter_write[0] |=> channel_counter_value[15:0] == ZERO_WIDE;
  endproperty
  a_join_clear: assert property (p_join_clear) else $error("joined counter not cleared");
  property p_stop; !join_pair_2_3 && !channel_enable_bit[2] && !counter_write[2]
    && channel_period_value[23:16] != ZERO_BYTE ##1 !join_pair_2_3
    |-> $stable(channel_counter_value[23:16]); endproperty
  a_stop: assert property (p_stop) else $error("disabled counter moved");
  property p_left_step; !join_pair_4_5 && !center_align_select[4] ##1 !join_pair_4_5
    |-> c4 == ZERO_BYTE || $stable(c4) || c4 == $past(c4) + 8'h01; endproperty
  a_left_step: assert property (p_left_step) else $error("left counter did not step up");
  property p_center_step; !join_pair_4_5 && center_align_select[5] ##1 !join_pair_4_5
    |-> c5 == ZERO_BYTE || $stable(c5) || c5 == $past(c5) + 8'h01 || c5 == $past(c5) - 8'h01; endproperty
  a_center_step: assert property (p_center_step) else $error("center counter jumped");
  property p_zero_period; (clk_en && !join_pair_6_7 && !channel_enable_bit[6]
    && channel_period_value[55:48] == ZERO_BYTE) [*4] ##1 !join_pair_6_7
    |-> channel_counter_value[55:48] == ZERO_BYTE; endproperty
  a_zero_period: assert property (p_zero_period) else $error("counter not held at zero");
endmodule

bind pwm_channel_waveform_timers pwm_timers_checker #(.CHANNELS(CHANNELS)) chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .channel_enable_bit(channel_enable_bit),
  .center_align_select(center_align_select), .join_pair_0_1(join_pair_0_1), .join_pair_2_3(join_pair_2_3),
  .join_pair_4_5(join_pair_4_5), .join_pair_6_7(join_pair_6_7), .channel_period_value(channel_period_value),
  .counter_write(counter_write), .channel_counter_value(channel_counter_value), .channel_out(channel_out),
  .channel_out_en(channel_out_en));

// *** sim/tb_top.sv ***
// tb_top: random and corner-case bench for the eight waveform timers.
// assumes counters step on each enabled tick and the output trails the count by one edge.
`timescale 1ns/100ps
module tb_top;
  import pwm_timer_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        rst_b     = 1'b0;
  logic        clk_en    = 1'b1;
  logic        tick_b    = 1'b0;
  logic [1:0]  tick_s    = 2'b00;
  logic [7:0]  en        = 8'h00;
  logic [7:0]  ca        = 8'h00;
  logic [7:0]  pol       = 8'h00;
  logic [7:0]  csel      = 8'h00;
  logic [3:0]  jn        = 4'h0;
  logic [63:0] per       = {8{8'h05}};
  logic [63:0] dty       = {8{8'h02}};
  logic [7:0]  cw        = 8'h00;
  logic [63:0] cnt;
  logic [7:0]  out;
  logic [7:0]  oen;
  logic [31:0] seed      = 32'h0000_004F;
  int          err_total = 0;
  int          checked   = 0;
  int          cyc       = 0;

  pwm_channel_waveform_timers uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .tick_a(1'b1), .tick_b(tick_b), .tick_sa(tick_s[0]),
    .tick_sb(tick_s[1]), .channel_enable_bit(en), .center_align_select(ca), .channel_polarity_bit(pol),
    .channel_clock_select(csel), .join_pair_0_1(jn[0]), .join_pair_2_3(jn[1]), .join_pair_4_5(jn[2]),
    .join_pair_6_7(jn[3]), .channel_period_value(per), .channel_duty_value(dty), .counter_write(cw),
    .channel_counter_value(cnt), .channel_out(out), .channel_out_en(oen));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic fout(int c, bit up, int pa, int da, bit p, bit m);
    if (pa == 0 || (da >= pa && da > 0)) return p;
    if (da == 0) return !p;
    return p ^ (m && !up ? c > da : c >= da);
  endfunction

  task automatic chk_cnt(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t counter %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t output %b expected %b", $time, got, exp);
    end
  endtask

  // channels 2..7 churn in the background; joins move only while they are off
  task automatic tick();
    @(posedge sys_clk);
    #1;
    cyc++;
    tick_b = ~tick_b;
    tick_s = 2'(rnd());
    cw[7:2] = 6'(rnd() & rnd() & rnd());
    case (cyc % 64)
      0: en[7:2] = 6'h00;
      1: begin
        jn[3:1] = 3'(rnd());
        {ca[7:2], pol[7:2]} = 12'(rnd());
        csel[7:2] = 6'(rnd()) & 6'h2F;
        per[63:16] = {rnd(), 16'(rnd())};
        dty[63:16] = {rnd(), 16'(rnd())};
        per[16] = 1'b1;
        per[55:48] &= {8{cyc[7]}};
      end
      2: en[7:2] = 6'(rnd());
      default: ;
    endcase
  endtask

  // channel 1 (or pair 0/1) against a reference count and waveform
  task automatic walk(string nm, bit j, bit m, bit p, int pv, int dv, int n);
    int c, pa, da, pb, db, skip;
    bit up, oe, w;
    logic [15:0] got;
    clk_en = 1'b1;
    en[1:0] = 2'b00;
    tick();
    jn[0] = j;
    ca[1:0] = {m, !m};
    pol[1:0] = {p, !p};
    csel[1:0] = 2'b01;
    per[15:0] = {pv[7:0], j ? pv[15:8] : 8'(rnd())};
    dty[15:0] = {dv[7:0], j ? dv[15:8] : 8'(rnd())};
    tick();
    cw[1] = 1'b1;
    tick();
    cw[1] = 1'b0;
    en[1:0] = {1'b1, 1'(rnd())};
    pa = pv; da = dv; pb = pv; db = dv; up = 1; skip = 2; got = 16'h0000;
    for (int i = 0; i < 4 && got == 16'h0000; i++) begin
      tick();
      got = j ? {cnt[7:0], cnt[15:8]} : {8'h00, cnt[15:8]};
    end
    c = pv == 0 ? 0 : 1;
    chk_cnt(got, 16'(c));
    for (int i = 0; i < n; i++) begin
      clk_en = (rnd() % 8) != 0;
      w = clk_en && i == n / 2;
      cw[j ? 0 : 1] = w;
      if (i == n / 3) begin
        pb = pv + 1;
        per[15:0] = {pb[7:0], j ? pb[15:8] : per[7:0]};
      end
      tick();
      if (clk_en) begin
        oe = fout(c, up, pa, da, p, m);
        if (skip > 0) skip--;
        if (w) begin
          c = 0; up = 1; pa = pb; da = db; skip = 2;
        end else if (pa == 0) begin
          c = 0;
          pa = pb;
          da = db;
        end else if (!m) begin
          c++;
          if (c >= pa) begin
            c = 0; pa = pb; da = db; skip = 2;
          end
        end else begin
          if (c == 0) up = 1;
          else if (up && c >= pa) up = 0;
          c = up ? c + 1 : c - 1;
          if (c == 0) begin
            pa = pb; da = db; skip = 2;
          end
        end
        if (skip == 0) chk_bit(out[1], oe);
      end
      got = j ? {cnt[7:0], cnt[15:8]} : {8'h00, cnt[15:8]};
      chk_cnt(got, 16'(c));
      chk_cnt(16'(oen[1:0]), 16'({1'b1, !j && en[0]}));
    end
    cw[1:0] = 2'b00;
    clk_en = 1'b1;
    $display("test %0s done", nm);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    chk_cnt(cnt[15:0] | cnt[31:16] | cnt[47:32] | cnt[63:48], 16'h0000);
    chk_cnt({8'h00, oen}, 16'h0000);
    for (int k = 0; k < 12; k++) begin
      int pv;
      pv = 2 + rnd() % 40;
      walk("modes", 0, k[0], k[1], pv, k < 4 ? rnd() % pv : k < 8 ? 0 : pv + rnd() % 3, 3 * pv + 12);
    end
    walk("zero period left", 0, 0, 1, 0, 3, 12);
    walk("zero period center", 0, 1, 0, 0, 3, 12);
    walk("joined left", 1, 0, 0, 16'h0102, 16'h0081, 800);
    walk("joined center", 1, 1, 1, 16'h0103, 16'h0005, 1200);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end
endmodule
